// ==== test/sdr_hall_model.sv ====
// shaft position sensor model for the safe direction reversal bench
`timescale 1ns/100ps
module sdr_hall_model
    import sdr_pkg::*;
(
    input  wire logic clock,
    input  wire logic step,
    input  wire logic rev,
    output logic      shaft_position_a,
    output logic      shaft_position_b,
    output logic      shaft_position_c
);
    // six sectors, one bit flips per step since sensors sit 120 degrees apart
    sdr_hall_t   seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    int unsigned idx     = 0; // current sector
    // wrap the index so no all-zero or all-one code can appear
    always @(posedge clock)
    begin
        if (step)
            idx <= rev ? (idx + 5) % 6 : (idx + 1) % 6;
    end
    assign {shaft_position_c, shaft_position_b, shaft_position_a} = seq[idx];
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the safe direction reversal core
`timescale 1ns/100ps
module testbench
    import sdr_pkg::*;
;
    logic       clock = 0, rst = 1, direction_req = 0, speed_low = 0;
    logic       osc_tick = 0, pwm_trip = 0, step = 0, hall_rev = 0, seen;
    logic       pa, pb, pc, inhib, tach;
    sdr_phase_t high, low;
    int         failures = 0, n_tests = 0;
    always #12.5 clock = ~clock;
    sdr_core u_sdr_core (.clock(clock), .rst(rst), .direction_req(direction_req), .speed_low(speed_low),
        .osc_tick(osc_tick), .pwm_trip(pwm_trip), .shaft_position_a(pa), .shaft_position_b(pb),
        .shaft_position_c(pc), .high_side_drive(high), .low_side_drive(low), .drive_inhibit(inhib),
        .tach_pulse(tach));
    sdr_hall_model u_sdr_hall_model (.clock(clock), .step(step), .rev(hall_rev),
        .shaft_position_a(pa), .shaft_position_b(pb), .shaft_position_c(pc));
    task automatic check(string what, logic [7:0] s, logic [7:0] e);
        n_tests++;
        if (s !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    // expected {high, low} for a sector; reverse swaps the two sides
    function automatic logic [5:0] exp_drv(sdr_hall_t h, logic d, logic trip);
        logic [2:0] hi, lo;
        case (h)
            3'h1: {hi, lo} = {3'h1, 3'h2};
            3'h3: {hi, lo} = {3'h1, 3'h4};
            3'h2: {hi, lo} = {3'h2, 3'h4};
            3'h6: {hi, lo} = {3'h2, 3'h1};
            3'h4: {hi, lo} = {3'h4, 3'h1};
            3'h5: {hi, lo} = {3'h4, 3'h2};
            default: {hi, lo} = 6'h00;
        endcase
        if (d)
            {hi, lo} = {lo, hi};
        return trip ? {3'h0, lo} : {hi, lo};
    endfunction
    task automatic cyc(int n);
        repeat (n) @(posedge clock);
    endtask
    // one oscillator period, slow enough for the input synchronisers
    task automatic tick();
        osc_tick <= 1;
        cyc(3);
        osc_tick <= 0;
        cyc(9);
    endtask
    // toggle the request and look for a tach pulse in a bounded window
    task automatic toggle();
        direction_req <= ~direction_req;
        seen = 0;
        // look mid-cycle, away from the edge that launches the pulse
        repeat (12)
        begin
            @(negedge clock);
            seen |= (tach === 1'b1);
        end
        cyc(1);
        check("tach", {7'h00, seen}, 8'h01);
    endtask
    // compare half a cycle after the launching edge; no toggle is recent here
    task automatic drv(string what, logic d, logic trip);
        @(negedge clock);
        check(what, {2'h0, high, low}, {2'h0, exp_drv({pc, pb, pa}, d, trip)});
        check({what, " tach"}, {7'h00, tach}, 8'h00);
        @(posedge clock);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog cuts a hang short
    initial
    begin
        #(25 * 40000);
        failures++;
        end_sim();
    end
    initial
    begin
        void'($urandom(32'h0f251bae));
        cyc(3);
        @(negedge clock);
        check("reset", {high, low, inhib, tach}, 8'h02);
        @(posedge clock);
        rst <= 0;
        $display("test reset done");
        speed_low <= 1;
        tick();
        tick();
        @(negedge clock);
        check("inhibit", {7'h00, inhib}, 8'h00);
        @(posedge clock);
        repeat (12)
        begin
            hall_rev <= 1'($urandom % 2);
            step <= 1;
            cyc(1);
            step <= 0;
            cyc(7);
            drv("decode", 1'b0, 1'b0);
        end
        $display("test decode done");
        for (int i = 0; i < 2; i++)
        begin
            toggle();
            cyc(20);
            @(negedge clock);
            check("inhibit", {1'b0, inhib, high, low}, 8'h40);
            @(posedge clock);
            tick();
            @(negedge clock);
            check("inhibit", {7'h00, inhib}, 8'h01);
            @(posedge clock);
            tick();
            drv("reversed", ~i[0], 1'b0);
        end
        $display("test reversal done");
        speed_low <= 0;
        toggle();
        tick();
        tick();
        @(negedge clock);
        check("held", {1'b0, inhib, high, low}, 8'h40);
        @(posedge clock);
        toggle();
        tick();
        tick();
        drv("held", 1'b0, 1'b0);
        $display("test latch hold done");
        pwm_trip <= 1;
        cyc(2);
        pwm_trip <= 0;
        cyc(6);
        drv("chop", 1'b0, 1'b1);
        tick();
        drv("chop end", 1'b0, 1'b0);
        $display("test chop done");
        end_sim();
    end
endmodule

// ==== verilog/sdr_cfg.svh ====
// constants for the safe direction reversal block
`ifndef SDR_CFG_SVH
`define SDR_CFG_SVH
`define SDR_CLOCK_NS       25
`define SDR_MIN_DELAY_NS   500
`define SDR_MAX_DELAY_NS   50000
`define SDR_DEAD_TIME_NS   25000
`define SDR_DEAD_CYCLES    ((`SDR_DEAD_TIME_NS + `SDR_CLOCK_NS - 1) / `SDR_CLOCK_NS)
`define SDR_TACH_CYCLES    4
`define SDR_SHIFT_DEPTH    2
`endif

// ==== verilog/sdr_core.sv ====
// direction latch, shift register, drive inhibit and tach pulse
// What this block does
// - decode shaft position and direction to drives
// - latch direction then shift two bits
// - latch transparent while speed is low
// - drives off while latch input differs
// - drives off while shift register differs
// - shift register advances on oscillator ticks only
// - reversal delay between 0.5 and 50 us
// - about 25 us dead time is adequate
// - each direction toggle pulses tach output
// - comparator trip chops rest of cycle
`timescale 1ns/100ps
`include "sdr_cfg.svh"
module sdr_core
    import sdr_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       direction_req,
    input  wire logic       speed_low,
    input  wire logic       osc_tick,
    input  wire logic       pwm_trip,
    input  wire logic       shaft_position_a,
    input  wire logic       shaft_position_b,
    input  wire logic       shaft_position_c,
    output sdr_phase_t      high_side_drive,
    output sdr_phase_t      low_side_drive,
    output logic            drive_inhibit,
    output logic            tach_pulse
);
    // two-stage synchronisers for every pin input
    logic [6:0] sync1_q;                 // first stage, read only by second
    logic [6:0] sync2_q;                 // second stage, safe to use
    logic [6:0] pins_w;                  // raw pin bundle
    assign pins_w = {pwm_trip, osc_tick, speed_low, direction_req,
                     shaft_position_c, shaft_position_b, shaft_position_a};
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sync1_q <= 7'h00;
            sync2_q <= 7'h00;
        end
        else
        begin
            sync1_q <= pins_w;
            sync2_q <= sync1_q;
        end
    end

    logic       dir_s;                   // synchronised direction request
    logic       slow_s;                  // synchronised low-speed flag
    logic       osc_s;                   // synchronised oscillator level
    logic       trip_s;                  // synchronised comparator trip
    sdr_hall_t  hall_s;                  // synchronised shaft position
    assign hall_s = sync2_q[2:0];
    assign dir_s  = sync2_q[3];
    assign slow_s = sync2_q[4];
    assign osc_s  = sync2_q[5];
    assign trip_s = sync2_q[6];

    // state: latch, two-bit shift, oscillator edge, pwm latch, tach timer
    logic       latch_q, latch_d;        // direction latch output
    logic [1:0] shift_q, shift_d;        // direction shift register
    logic       osc_q, osc_d;            // previous oscillator level
    logic       pwm_q, pwm_d;            // pwm enable latch
    logic       dir_prev_q, dir_prev_d;  // last request, for toggle detection
    logic [2:0] tach_q, tach_d;          // tach pulse stretch counter
    logic       latch_in;                // what the latch would pass now
    logic       osc_rise;                // one oscillator tick
    logic       toggle;                  // direction request changed

    // next-state logic
    always_comb
    begin
        osc_rise = osc_s & ~osc_q;
        toggle   = dir_s ^ dir_prev_q;
        osc_d    = osc_s;
        dir_prev_d = dir_s;
        latch_in = dir_s;
        // transparent at low speed, holds at speed so reversal waits for coast
        latch_d  = slow_s ? latch_in : latch_q;
        // only oscillator ticks shift, so a reversal takes two ticks at least
        shift_d  = osc_rise ? {shift_q[0], latch_q} : shift_q;
        // new cycle re-arms pwm; a trip chops the remainder of it
        if (trip_s)
            pwm_d = 1'b0;
        else if (osc_rise)
            pwm_d = 1'b1;
        else
            pwm_d = pwm_q;
        // stretch each toggle to a visible pulse, speed does not matter
        if (toggle)
            tach_d = 3'(`SDR_TACH_CYCLES);
        else if (tach_q != 3'h0)
            tach_d = tach_q - 3'h1;
        else
            tach_d = 3'h0;
    end

    // registers only
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            latch_q    <= 1'b0;
            shift_q    <= 2'h0;
            osc_q      <= 1'b0;
            pwm_q      <= 1'b0;
            dir_prev_q <= 1'b0;
            tach_q     <= 3'h0;
        end
        else
        begin
            latch_q    <= latch_d;
            shift_q    <= shift_d;
            osc_q      <= osc_d;
            pwm_q      <= pwm_d;
            dir_prev_q <= dir_prev_d;
            tach_q     <= tach_d;
        end
    end

    // inhibit while any stage disagrees; dead time comes from oscillator period
    logic inhibit_w;                     // combined inhibit condition
    assign inhibit_w = (latch_in != latch_q) | (latch_q != shift_q[0]) |
                       (shift_q[0] != shift_q[1]);

    sdr_phase_t hi_sel;                  // decoder high-side choice
    sdr_phase_t lo_sel;                  // decoder low-side choice
    sdr_decoder u_dec
    (
        .hall      (~inhibit_w),         // blank both sides while reversing
        .hall_word (hall_s),             // single-bit steps keep decode glitch-free
        .direction (shift_q[1]),
        .high_sel  (hi_sel),
        .low_sel   (lo_sel)
    );

    // next values of the registered outputs
    sdr_phase_t high_d;                  // next high-side drives
    sdr_phase_t low_d;                   // next low-side drives
    logic       tach_on;                 // tach stretch still running
    always_comb
    begin
        // trip gates the high side only, so winding current recirculates low
        high_d  = hi_sel & {3{pwm_q}};
        low_d   = lo_sel;
        tach_on = (tach_q != 3'h0);
    end

    // output flops so drives never glitch
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            high_side_drive <= 3'h0;
            low_side_drive  <= 3'h0;
            drive_inhibit   <= 1'b1;
            tach_pulse      <= 1'b0;
        end
        else
        begin
            high_side_drive <= high_d;
            low_side_drive  <= low_d;
            drive_inhibit   <= inhibit_w;
            tach_pulse      <= tach_on;
        end
    end

    // checks
    // any disagreement blanks both sides on the next edge
    property p_inhibit_off;
        @(posedge clock) disable iff (rst)
        inhibit_w |=> (high_side_drive == 3'h0 && low_side_drive == 3'h0);
    endproperty
    a_inhibit_off: assert property (p_inhibit_off)
        else $error("drives on during inhibit");

    // a half-shifted direction must show as inhibit
    property p_shift_inhibit;
        @(posedge clock) disable iff (rst)
        (shift_q[0] != shift_q[1]) |=> drive_inhibit;
    endproperty
    a_shift_inhibit: assert property (p_shift_inhibit)
        else $error("shift mismatch not inhibited");

    // at speed the latch ignores the request
    property p_latch_hold;
        @(posedge clock) disable iff (rst)
        !slow_s |=> $stable(latch_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch moved at speed");

    // at low speed the latch follows the request
    property p_latch_pass;
        @(posedge clock) disable iff (rst)
        slow_s |=> latch_q == $past(dir_s);
    endproperty
    a_latch_pass: assert property (p_latch_pass)
        else $error("latch not transparent");

    // no oscillator tick, no shift
    property p_shift_idle;
        @(posedge clock) disable iff (rst)
        !osc_rise |=> $stable(shift_q);
    endproperty
    a_shift_idle: assert property (p_shift_idle)
        else $error("shift without tick");

    // a tick loads the latch output into the first stage
    property p_shift_load;
        @(posedge clock) disable iff (rst)
        osc_rise |=> shift_q[0] == $past(latch_q);
    endproperty
    a_shift_load: assert property (p_shift_load)
        else $error("shift lost value");

    // a tick moves the first stage into the second
    property p_shift_next;
        @(posedge clock) disable iff (rst)
        osc_rise |=> shift_q[1] == $past(shift_q[0]);
    endproperty
    a_shift_next: assert property (p_shift_next)
        else $error("second stage lost value");

    // a toggle shows on the tach output two edges on
    property p_tach_start;
        @(posedge clock) disable iff (rst)
        toggle |=> ##1 tach_pulse;
    endproperty
    a_tach_start: assert property (p_tach_start)
        else $error("no tach pulse");

    // each pulse is long enough to be seen outside
    property p_tach_len;
        @(posedge clock) disable iff (rst)
        $rose(tach_pulse) |-> tach_pulse [*4];
    endproperty
    a_tach_len: assert property (p_tach_len)
        else $error("tach pulse too short");

    // a trip clears the pwm latch and then the high side
    property p_trip_chop;
        @(posedge clock) disable iff (rst)
        trip_s |=> !pwm_q ##1 (high_side_drive == 3'h0);
    endproperty
    a_trip_chop: assert property (p_trip_chop)
        else $error("trip did not chop");

    // never both switches of one leg at once
    property p_no_overlap;
        @(posedge clock) disable iff (rst)
        (high_side_drive & low_side_drive) == 3'h0;
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("cross conduction on a leg");
endmodule

// ==== verilog/sdr_decoder.sv ====
// commutation decoder from shaft position and direction to phase drives
`timescale 1ns/100ps
module sdr_decoder
    import sdr_pkg::*;
(
    input  wire logic       hall,        // drive enable, low blanks both sides
    input  wire logic [2:0] hall_word,
    input  wire logic       direction,
    output sdr_phase_t      high_sel,
    output sdr_phase_t      low_sel
);
    // table for forward rotation; reverse swaps high and low selections
    always_comb
    begin
        sdr_phase_t hi;
        sdr_phase_t lo;
        hi = 3'h0;
        lo = 3'h0;
        case (hall_word)
            3'h1:
            begin
                hi = 3'h1;
                lo = 3'h2;
            end
            3'h3:
            begin
                hi = 3'h1;
                lo = 3'h4;
            end
            3'h2:
            begin
                hi = 3'h2;
                lo = 3'h4;
            end
            3'h6:
            begin
                hi = 3'h2;
                lo = 3'h1;
            end
            3'h4:
            begin
                hi = 3'h4;
                lo = 3'h1;
            end
            3'h5:
            begin
                hi = 3'h4;
                lo = 3'h2;
            end
            default:
            begin
                // illegal codes drive nothing, a broken sensor cannot short a leg
                hi = 3'h0;
                lo = 3'h0;
            end
        endcase
        high_sel = (direction ? lo : hi) & {3{hall}};
        low_sel  = (direction ? hi : lo) & {3{hall}};
    end
endmodule

// ==== verilog/sdr_pkg.sv ====
// types for the safe direction reversal block
package sdr_pkg;
    typedef logic [2:0] sdr_phase_t;   // one bit per motor phase
    typedef logic [2:0] sdr_hall_t;    // shaft position word c,b,a
endpackage
